// >>> src/bpsp_map.svh
// Register offsets, field positions, reset values and widths of the buffered slave port
`ifndef BPSP_MAP_SVH
`define BPSP_MAP_SVH

`define BPSP_OFF_MODE      12'h000
`define BPSP_OFF_STATUS    12'h004
`define BPSP_OFF_OUTDATA   12'h008
`define BPSP_OFF_INDATA    12'h00c
`define BPSP_OFF_IRQSTAT   12'h010
`define BPSP_OFF_IRQCLR    12'h014
`define BPSP_OFF_IRQEN     12'h018

`define BPSP_MODE_INCREMENT_MODE_FIELD_LO  0
`define BPSP_MODE_INTERRUPT_MODE_FIELD_LO  2
`define BPSP_INCREMENT_MODE_FIELD_BUFFERED 2'h3
`define BPSP_INTERRUPT_MODE_FIELD_EVERY    2'h1
`define BPSP_INTERRUPT_MODE_FIELD_FOURTH   2'h3
`define BPSP_MODE_RESET    4'h0

`define BPSP_ST_OBE_LO     0
`define BPSP_ST_OUT_BUF_ERROR_FLAG       4
`define BPSP_ST_OBALL      5
`define BPSP_ST_IBF_LO     8
`define BPSP_ST_IN_BUF_OVERFLOW_FLAG       12
`define BPSP_ST_IBALL      13

`define BPSP_EV_PORT       0
`define BPSP_EV_OUT_BUF_ERROR_FLAG       1
`define BPSP_EV_IN_BUF_OVERFLOW_FLAG       2
`define BPSP_NUM_EVENTS    3

`define BPSP_LAST_BUF      2'h3
`endif

// >>> src/bpsp_pkg.sv
// Types shared by the buffered slave port
package bpsp_pkg;
    typedef enum logic [1:0] {BPSP_OKAY = 2'h0, BPSP_SLVERR = 2'h2} bpsp_resp_t;
    typedef logic [1:0] bpsp_idx_t;
endpackage : bpsp_pkg

// >>> src/bpsp_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/100ps
module bpsp_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] async,
    output logic      [WIDTH-1:0] synced
);
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            stage1 <= '0;
            synced <= '0;
        end
        else
        begin
            stage1 <= async;
            synced <= stage1;
        end
    end
endmodule : bpsp_sync

// >>> src/bpsp_bufmem.sv
// Four-entry byte buffer with registered read data
`timescale 1ns/100ps
module bpsp_bufmem #(
    parameter int DEPTH = 4,
    parameter int AW    = 2
) (
    input  wire logic          clk,
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [7:0]    wdata,
    input  wire logic [AW-1:0] raddr,
    output logic      [7:0]    rdata
);
    logic [7:0] mem [DEPTH];

    always_ff @(posedge clk)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule : bpsp_bufmem

// >>> src/bpsp_port.sv
// Buffered parallel slave port with AXI4-Lite register access
// Behaviour
// - Buffered behaviour is active only while the increment-mode field holds 11; otherwise strobes are ignored.
// - Four byte buffers exist in each direction, input buffers written by the master, output buffers read by it.
// - Buffers are indexed 0 to 3, index 0 the lowest byte of the data word and 3 the highest.
// - Each read strobe drives one output byte, taken in order from buffer 0 through buffer 3.
// - An internal read pointer selects the next output buffer and advances after every read strobe.
// - Each output buffer has an empty bit, cleared when software loads it and set when its byte is driven.
// - A read strobe on an empty output buffer sets the output-buffer error flag.
// - The all-empty output flag is high whenever all four output empty bits are set.
// - Write strobes fill input buffers 0 to 3 in order, chosen by an internal write pointer.
// - Each input buffer has a full bit, set by the write strobe that loads it and cleared when software reads it.
// - A write strobe on a full input buffer sets the input-overflow flag and the new byte is lost.
// - The all-full input flag is high whenever all four input full bits are set.
// - With interrupt mode 01 the port interrupt is raised on every read and write strobe.
// - With interrupt mode 11 the port interrupt is raised only on accesses to buffer 3.
`timescale 1ns/100ps
`include "bpsp_map.svh"
module bpsp_port (
    input  wire logic        clk,
    input  wire logic        rst_n,
    // AXI4-Lite slave
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Parallel pins
    input  wire logic        chipSel_n,
    input  wire logic        readStrobe_n,
    input  wire logic        writeStrobe_n,
    input  wire logic [7:0]  pinData_in,
    output logic [7:0]       pinData_out,
    output logic             pinData_oe,
    output logic             irq
);
    localparam int NB = 4;

    // Pin synchronisation
    logic [10:0] pinSync;
    bpsp_sync #(.WIDTH(11)) uSync (
        .clk    (clk),
        .rst_n  (rst_n),
        .async  ({~chipSel_n, ~readStrobe_n, ~writeStrobe_n, pinData_in}),
        .synced (pinSync)
    );
    wire       csAct   = pinSync[10];
    wire       rdLvl   = pinSync[9] & csAct;
    wire       wrLvl   = pinSync[8] & csAct;
    wire [7:0] pinByte = pinSync[7:0];

    logic rdLvlD;
    logic wrLvlD;

    // Control and state
    logic [3:0]        modeReg;
    logic [NB-1:0]     outEmpty;
    logic [NB-1:0]     inFull;
    logic              outErr;
    logic              inOvf;
    bpsp_pkg::bpsp_idx_t rdPtr;
    bpsp_pkg::bpsp_idx_t wrPtr;
    logic [`BPSP_NUM_EVENTS-1:0] irqStat;
    logic [`BPSP_NUM_EVENTS-1:0] irqEn;
    logic [7:0]        outBuf [NB];

    wire [1:0] incmField = modeReg[`BPSP_MODE_INCREMENT_MODE_FIELD_LO +: 2];
    wire [1:0] irqmField = modeReg[`BPSP_MODE_INTERRUPT_MODE_FIELD_LO +: 2];
    wire       bufMode   = (incmField == `BPSP_INCREMENT_MODE_FIELD_BUFFERED);

    wire rdStrobe = bufMode & rdLvl & ~rdLvlD;
    wire wrStrobe = bufMode & wrLvl & ~wrLvlD & ~rdLvl;

    // Input buffers live in a small memory; read data is registered
    logic [7:0] inRdData;
    logic [1:0] inRdIdx;
    wire        inLoad = wrStrobe & ~inFull[wrPtr];
    bpsp_bufmem #(.DEPTH(NB), .AW(2)) uInBuf (
        .clk   (clk),
        .we    (inLoad),
        .waddr (wrPtr),
        .wdata (pinByte),
        .raddr (inRdIdx),
        .rdata (inRdData)
    );

    // AXI4-Lite decode
    logic        awHeld;
    logic        wHeld;
    logic [11:0] awAddr;
    logic [31:0] wData;
    logic [3:0]  wStrb;
    logic        rdPend;
    logic [11:0] arAddr;
    wire         doWrite = awHeld & wHeld & ~s_axi_bvalid;
    wire         wrMode  = doWrite & (awAddr == `BPSP_OFF_MODE);
    wire         wrOut   = doWrite & (awAddr == `BPSP_OFF_OUTDATA);
    wire         wrClr   = doWrite & (awAddr == `BPSP_OFF_IRQCLR);
    wire         wrEn    = doWrite & (awAddr == `BPSP_OFF_IRQEN);
    wire         wrStat  = doWrite & (awAddr == `BPSP_OFF_STATUS);
    wire         wrOk    = wrMode | wrOut | wrClr | wrEn | wrStat
                         | (awAddr == `BPSP_OFF_INDATA) | (awAddr == `BPSP_OFF_IRQSTAT);
    // Read: the memory needs one cycle, so an accepted read is answered one cycle later
    wire         takeAr  = s_axi_arvalid & s_axi_arready;
    wire         rdIn    = rdPend & (arAddr == `BPSP_OFF_INDATA);
    assign inRdIdx = 2'h0;

    // Input data register read returns all four buffers; a read clears every full bit except one set by a write strobe in the same cycle
    logic [7:0] inSnap [NB];
    logic [1:0] snapIdx;

    // Status word
    wire        outAllEmpty = &outEmpty;
    wire        inAllFull   = &inFull;
    wire [31:0] statusWord  = {18'h0, inAllFull, inOvf, inFull, 2'h0, outAllEmpty, outErr, outEmpty};

    // Events
    wire portEv = (irqmField == `BPSP_INTERRUPT_MODE_FIELD_EVERY) & (rdStrobe | wrStrobe)
                | (irqmField == `BPSP_INTERRUPT_MODE_FIELD_FOURTH)
                  & ((rdStrobe & (rdPtr == `BPSP_LAST_BUF)) | (wrStrobe & (wrPtr == `BPSP_LAST_BUF)));
    wire obufEv = rdStrobe & outEmpty[rdPtr];
    wire ibovEv = wrStrobe & inFull[wrPtr];
    wire [`BPSP_NUM_EVENTS-1:0] evVec = {ibovEv, obufEv, portEv};

    // Output buffers, input full bits and input snapshots, per entry
    genvar g;
    generate
        for (g = 0; g < NB; g++)
        begin : gBuf
            wire loadOut = wrOut & wStrb[g];
            wire sentOut = rdStrobe & (rdPtr == 2'(g));
            wire fillIn  = inLoad & (wrPtr == 2'(g));
            always_ff @(posedge clk)
            begin
                if (!rst_n)
                begin
                    outBuf[g]   <= 8'h00;
                    outEmpty[g] <= 1'b1;
                    inFull[g]   <= 1'b0;
                    inSnap[g]   <= 8'h00;
                end
                else
                begin
                    if (loadOut)
                        outBuf[g] <= wData[8*g +: 8];
                    // Driving the byte wins over a same-cycle load: the load data is then sent next lap
                    if (sentOut)
                        outEmpty[g] <= 1'b1;
                    else if (loadOut)
                        outEmpty[g] <= 1'b0;
                    if (fillIn)
                        inFull[g] <= 1'b1;
                    else if (rdIn)
                        inFull[g] <= 1'b0;
                    if (fillIn)
                        inSnap[g] <= pinByte;
                end
            end
        end
    endgenerate

    wire [31:0] inWord = {inSnap[3], inSnap[2], inSnap[1], inSnap[0]};

    logic [31:0] next_rdata;
    always_comb
    begin
        unique case (arAddr)
            `BPSP_OFF_MODE:    next_rdata = {28'h0, modeReg};
            `BPSP_OFF_STATUS:  next_rdata = statusWord;
            `BPSP_OFF_OUTDATA: next_rdata = {outBuf[3], outBuf[2], outBuf[1], outBuf[0]};
            `BPSP_OFF_INDATA:  next_rdata = inWord;
            `BPSP_OFF_IRQSTAT: next_rdata = {29'h0, irqStat};
            `BPSP_OFF_IRQEN:   next_rdata = {29'h0, irqEn};
            default:           next_rdata = 32'h0;
        endcase
    end
    wire rdOk = (arAddr == `BPSP_OFF_MODE) | (arAddr == `BPSP_OFF_STATUS) | (arAddr == `BPSP_OFF_OUTDATA)
              | (arAddr == `BPSP_OFF_INDATA) | (arAddr == `BPSP_OFF_IRQSTAT) | (arAddr == `BPSP_OFF_IRQEN);

    // Ready outputs are registered: each carries what the held and pending state will allow after this edge
    wire next_awReady = ~doWrite & ~awHeld & ~(s_axi_awvalid & s_axi_awready)
                      & ~(s_axi_bvalid & ~s_axi_bready);
    wire next_wReady  = ~doWrite & ~wHeld & ~(s_axi_wvalid & s_axi_wready)
                      & ~(s_axi_bvalid & ~s_axi_bready);
    wire next_arReady = ~rdPend & ~takeAr & ~(s_axi_rvalid & ~s_axi_rready);

    // Bus handshake registers
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            awHeld <= 1'b0; wHeld <= 1'b0; awAddr <= 12'h000; wData <= 32'h0; wStrb <= 4'h0;
            s_axi_bvalid <= 1'b0; s_axi_bresp <= 2'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_arready <= 1'b1;
            rdPend <= 1'b0; arAddr <= 12'h000; s_axi_rvalid <= 1'b0; s_axi_rdata <= 32'h0; s_axi_rresp <= 2'h0;
        end
        else
        begin
            s_axi_awready <= next_awReady;
            s_axi_wready <= next_wReady;
            s_axi_arready <= next_arReady;
            if (s_axi_awvalid & s_axi_awready)
            begin
                awHeld <= 1'b1;
                awAddr <= {s_axi_awaddr[11:2], 2'h0};
            end
            if (s_axi_wvalid & s_axi_wready)
            begin
                wHeld <= 1'b1;
                wData <= s_axi_wdata;
                wStrb <= s_axi_wstrb;
            end
            if (doWrite)
            begin
                awHeld <= 1'b0;
                wHeld <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wrOk ? bpsp_pkg::BPSP_OKAY : bpsp_pkg::BPSP_SLVERR;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
            if (takeAr)
            begin
                rdPend <= 1'b1;
                arAddr <= {s_axi_araddr[11:2], 2'h0};
            end
            if (rdPend)
            begin
                rdPend <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= next_rdata;
                s_axi_rresp <= rdOk ? bpsp_pkg::BPSP_OKAY : bpsp_pkg::BPSP_SLVERR;
            end
            else if (s_axi_rvalid & s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // Port state
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            modeReg <= `BPSP_MODE_RESET;
            rdPtr <= 2'h0; wrPtr <= 2'h0;
            outErr <= 1'b0; inOvf <= 1'b0;
            irqStat <= '0; irqEn <= '0;
            rdLvlD <= 1'b0; wrLvlD <= 1'b0;
            pinData_out <= 8'h00; pinData_oe <= 1'b0; irq <= 1'b0;
        end
        else
        begin
            rdLvlD <= rdLvl;
            wrLvlD <= wrLvl;
            if (wrMode & wStrb[0])
                modeReg <= wData[3:0];
            if (rdStrobe)
            begin
                rdPtr <= rdPtr + 2'h1;
                pinData_out <= outBuf[rdPtr];
            end
            pinData_oe <= bufMode & rdLvl;
            if (wrStrobe)
                wrPtr <= wrPtr + 2'h1;
            // Flags set by hardware win over a same-cycle software clear
            if (obufEv)
                outErr <= 1'b1;
            else if (wrStat & wData[`BPSP_ST_OUT_BUF_ERROR_FLAG])
                outErr <= 1'b0;
            if (ibovEv)
                inOvf <= 1'b1;
            else if (wrStat & wData[`BPSP_ST_IN_BUF_OVERFLOW_FLAG])
                inOvf <= 1'b0;
            irqStat <= evVec | (irqStat & ~(wrClr ? wData[`BPSP_NUM_EVENTS-1:0] : '0));
            if (wrEn)
                irqEn <= wData[`BPSP_NUM_EVENTS-1:0];
            irq <= |((evVec | irqStat) & irqEn);
        end
    end

    // Checks
    full_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
        inAllFull == (inFull == 4'hf))
        else $error("all-full flag mismatch");
    empty_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
        outAllEmpty == (outEmpty == 4'hf))
        else $error("all-empty flag mismatch");
    rd_ptr_a: assert property (@(posedge clk) disable iff (!rst_n)
        rdStrobe |=> rdPtr == $past(rdPtr) + 2'h1)
        else $error("read pointer did not step");
    wr_ptr_a: assert property (@(posedge clk) disable iff (!rst_n)
        !wrStrobe |=> wrPtr == $past(wrPtr))
        else $error("write pointer moved without strobe");
    sequence emptyRead_s;
        rdStrobe && outEmpty[rdPtr];
    endsequence
    under_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
        emptyRead_s |=> outErr)
        else $error("underflow not flagged");
    ovf_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
        (wrStrobe && inFull[wrPtr]) |=> inOvf && $stable(wrPtr) == 1'b0)
        else $error("overflow not flagged");
    sent_empty_a: assert property (@(posedge clk) disable iff (!rst_n)
        rdStrobe |=> outEmpty[$past(rdPtr)])
        else $error("sent buffer not empty");
    fill_full_a: assert property (@(posedge clk) disable iff (!rst_n)
        (wrStrobe && !inFull[wrPtr]) |=> inFull[$past(wrPtr)])
        else $error("filled buffer not full");
    mode_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
        !bufMode |-> !rdStrobe && !wrStrobe)
        else $error("strobe outside buffered mode");
    fourth_irq_a: assert property (@(posedge clk) disable iff (!rst_n)
        (irqmField == 2'h3 && wrStrobe && wrPtr != 2'h3 && !rdStrobe) |-> !portEv)
        else $error("early fourth-byte event");
    every_irq_a: assert property (@(posedge clk) disable iff (!rst_n)
        (irqmField == 2'h1 && (rdStrobe || wrStrobe)) |-> portEv)
        else $error("strobe event missing");
endmodule : bpsp_port

// >>> bench/bpsp_pmaster.sv
// Behavioural external parallel bus master for the buffered slave port
`timescale 1ns/100ps
module bpsp_pmaster (
    input  wire logic       clk,
    output logic            chipSel_n,
    output logic            readStrobe_n,
    output logic            writeStrobe_n,
    output logic [7:0]      pinData_in,
    input  wire logic [7:0] pinData_out,
    input  wire logic       pinData_oe
);
    initial
    begin
        chipSel_n     = 1'b1;
        readStrobe_n  = 1'b1;
        writeStrobe_n = 1'b1;
        pinData_in    = 8'h00;
    end

    // One strobe per byte, inside chip select, never with the other strobe low
    task writeByte(input logic [7:0] b);
        @(posedge clk);
        chipSel_n  <= 1'b0;
        pinData_in <= b;
        @(posedge clk);
        writeStrobe_n <= 1'b0;
        repeat (6) @(posedge clk);
        writeStrobe_n <= 1'b1;
        // Data stays past the synchroniser, then the line no longer carries it
        repeat (2) @(posedge clk);
        chipSel_n  <= 1'b1;
        pinData_in <= ~b;
        repeat (3) @(posedge clk);
    endtask : writeByte

    task readByte(output logic [7:0] b, output logic oe);
        @(posedge clk);
        chipSel_n <= 1'b0;
        @(posedge clk);
        readStrobe_n <= 1'b0;
        repeat (6) @(posedge clk);
        b  = pinData_out;
        oe = pinData_oe;
        readStrobe_n <= 1'b1;
        repeat (2) @(posedge clk);
        chipSel_n <= 1'b1;
        repeat (3) @(posedge clk);
    endtask : readByte
endmodule : bpsp_pmaster

// >>> bench/bpsp_port_test.sv
// Self-checking testbench for the buffered slave port
`timescale 1ns/100ps
`include "bpsp_map.svh"
module bpsp_port_test;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [11:0] awAddr = 12'h000, arAddr = 12'h000;
    logic [31:0] wData = 32'h0, rData;
    logic [3:0]  wStrb = 4'hf;
    logic        awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
    logic        awReady, wReady, bValid, arReady, rValid, irq, pinOe;
    logic [1:0]  bResp, rResp;
    logic        chipSel_n, readStrobe_n, writeStrobe_n;
    logic [7:0]  pinIn, pinOut, b;
    logic        oe;
    logic [31:0] d;
    logic [1:0]  r;
    int          num_errors = 0, num_checks = 0, cycles = 0;

    always #20 clk = ~clk;

    bpsp_port dut (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
        .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid),
        .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
        .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
        .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady), .chipSel_n(chipSel_n),
        .readStrobe_n(readStrobe_n), .writeStrobe_n(writeStrobe_n), .pinData_in(pinIn),
        .pinData_out(pinOut), .pinData_oe(pinOe), .irq(irq));

    bpsp_pmaster pm (.clk(clk), .chipSel_n(chipSel_n), .readStrobe_n(readStrobe_n),
        .writeStrobe_n(writeStrobe_n), .pinData_in(pinIn), .pinData_out(pinOut), .pinData_oe(pinOe));

    task end_of_test;
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_of_test

    // Whole run is a few hundred cycles; this only cuts a hang short
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            end_of_test();
        end
    end

    task check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // Handshakes are judged in the low phase, where nothing changes, and acted on at the next edge
    task regWrite(input logic [11:0] a, input logic [31:0] v);
        logic ta, tw, got;
        got = 1'b0;
        @(posedge clk);
        awAddr  <= a;
        wData   <= v;
        awValid <= 1'b1;
        wValid  <= 1'b1;
        bReady  <= 1'b1;
        while (!got)
        begin
            @(negedge clk);
            ta = awValid && awReady;
            tw = wValid && wReady;
            got = bValid;
            r = bResp;
            @(posedge clk);
            if (ta) awValid <= 1'b0;
            if (tw) wValid <= 1'b0;
            if (got) bReady <= 1'b0;
        end
        // Registered outputs that follow the write settle before callers look at them
        @(negedge clk);
        check({30'h0, r}, {30'h0, bpsp_pkg::BPSP_OKAY});
    endtask : regWrite

    task regRead(input logic [11:0] a, output logic [31:0] v, output logic [1:0] resp);
        logic ta, got;
        got = 1'b0;
        @(posedge clk);
        arAddr  <= a;
        arValid <= 1'b1;
        rReady  <= 1'b1;
        while (!got)
        begin
            @(negedge clk);
            ta = arValid && arReady;
            got = rValid;
            v = rData;
            resp = rResp;
            @(posedge clk);
            if (ta) arValid <= 1'b0;
            if (got) rReady <= 1'b0;
        end
    endtask : regRead

    task expectReg(input logic [11:0] a, input logic [31:0] exp);
        regRead(a, d, r);
        check({30'h0, r}, {30'h0, bpsp_pkg::BPSP_OKAY});
        check(d, exp);
    endtask : expectReg

    initial
    begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        expectReg(`BPSP_OFF_STATUS, 32'h0000002f);
        expectReg(`BPSP_OFF_MODE, 32'h00000000);
        pm.writeByte(8'h5a);
        expectReg(`BPSP_OFF_STATUS, 32'h0000002f);
        $display("test reset and legacy mode done");

        regWrite(`BPSP_OFF_MODE, 32'h00000007);
        regWrite(`BPSP_OFF_IRQEN, 32'h00000007);
        regWrite(`BPSP_OFF_OUTDATA, 32'h44332211);
        expectReg(`BPSP_OFF_STATUS, 32'h00000000);
        for (int i = 0; i < 4; i++)
        begin
            pm.readByte(b, oe);
            check({24'h0, b}, 32'h11 * (i + 1));
            check({31'h0, oe}, 32'h1);
            check({31'h0, irq}, 32'h1);
            regWrite(`BPSP_OFF_IRQCLR, 32'h00000001);
            check({31'h0, irq}, 32'h0);
        end
        expectReg(`BPSP_OFF_STATUS, 32'h0000002f);
        $display("test buffered read done");

        for (int i = 0; i < 4; i++)
            pm.writeByte(8'ha0 + 8'(i));
        expectReg(`BPSP_OFF_STATUS, 32'h00002f2f);
        pm.writeByte(8'hee);
        expectReg(`BPSP_OFF_STATUS, 32'h00003f2f);
        expectReg(`BPSP_OFF_INDATA, 32'ha3a2a1a0);
        expectReg(`BPSP_OFF_STATUS, 32'h0000102f);
        regWrite(`BPSP_OFF_STATUS, 32'h00001000);
        expectReg(`BPSP_OFF_STATUS, 32'h0000002f);
        pm.readByte(b, oe);
        expectReg(`BPSP_OFF_STATUS, 32'h0000003f);
        expectReg(`BPSP_OFF_IRQSTAT, 32'h00000007);
        check({31'h0, irq}, 32'h1);
        regWrite(`BPSP_OFF_IRQEN, 32'h00000000);
        check({31'h0, irq}, 32'h0);
        regWrite(`BPSP_OFF_IRQCLR, 32'h00000007);
        expectReg(`BPSP_OFF_IRQSTAT, 32'h00000000);
        regRead(12'h01c, d, r);
        check(d, 32'h0);
        check({30'h0, r}, {30'h0, bpsp_pkg::BPSP_SLVERR});
        $display("test write, errors and interrupts done");

        // Second reset in mid-run brings both pointers back to buffer 0
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        expectReg(`BPSP_OFF_STATUS, 32'h0000002f);
        regWrite(`BPSP_OFF_MODE, 32'h0000000f);
        regWrite(`BPSP_OFF_IRQEN, 32'h00000001);
        regWrite(`BPSP_OFF_OUTDATA, 32'h04030201);
        for (int i = 0; i < 4; i++)
        begin
            pm.readByte(b, oe);
            check({24'h0, b}, 32'(i + 1));
            check({31'h0, irq}, {31'h0, i == 3});
        end
        regWrite(`BPSP_OFF_IRQCLR, 32'h00000001);
        for (int i = 0; i < 4; i++)
        begin
            pm.writeByte(8'hb0 + 8'(i));
            check({31'h0, irq}, {31'h0, i == 3});
        end
        expectReg(`BPSP_OFF_INDATA, 32'hb3b2b1b0);
        pm.writeByte(8'hc0);
        expectReg(`BPSP_OFF_STATUS, 32'h0000012f);
        // Only lane 0 is written, so only buffer 0 leaves the empty state
        wStrb <= 4'h1;
        regWrite(`BPSP_OFF_OUTDATA, 32'h88776655);
        expectReg(`BPSP_OFF_STATUS, 32'h0000010e);
        pm.readByte(b, oe);
        check({24'h0, b}, 32'h55);
        $display("test fourth-byte interrupt and wrap done");
        end_of_test();
    end
endmodule : bpsp_port_test
